// *** hdl/hbsre_pkg.sv ***
// Package: register map, fields, reset values and timing for the sideband block
package hbsre_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HBSRE_OFF_CTRL   = 8'h00;
  localparam logic [7:0] HBSRE_OFF_STATUS = 8'h04;
  localparam logic [7:0] HBSRE_OFF_REQCMD = 8'h08;
  localparam logic [7:0] HBSRE_OFF_CFG    = 8'h0c;
  localparam logic [7:0] HBSRE_OFF_EVENT  = 8'h10;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int HBSRE_CTRL_MC_EN      = 0;
  localparam int HBSRE_CTRL_MC_INTERNAL_ERROR_OUT    = 1;
  localparam int HBSRE_CTRL_MC_INIT    = 2;
  localparam int HBSRE_CTRL_MC_ANY     = 3;
  localparam int HBSRE_CTRL_TCC_EN     = 4;
  localparam int HBSRE_CTRL_TEMP_HOT   = 5;
  localparam int HBSRE_CTRL_INTERNAL_ERROR_OUT_SET   = 6;
  localparam int HBSRE_CTRL_TXN_ERR    = 7;
  localparam int HBSRE_CTRL_OWNER      = 8;
  localparam int HBSRE_CTRL_LAUNCH     = 9;
  localparam int HBSRE_CTRL_W          = 10;
  localparam logic [HBSRE_CTRL_W-1:0] HBSRE_CTRL_RST = 10'h000;
  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int HBSRE_ST_INTERNAL_ERROR_OUT   = 0;
  localparam int HBSRE_ST_TCC    = 1;
  localparam int HBSRE_ST_MCDRV  = 2;
  localparam int HBSRE_ST_MCIN   = 3;
  localparam int HBSRE_ST_PGOOD  = 4;
  localparam int HBSRE_ST_RESET  = 5;
  localparam int HBSRE_ST_BIST   = 6;
  localparam int HBSRE_ST_ALRMIN = 7;
  // Event sticky bits, write one to clear
  localparam int HBSRE_EV_PARERR = 0;
  localparam int HBSRE_EV_MCSEEN = 1;
  localparam int HBSRE_EV_W      = 2;
  localparam int HBSRE_REQ_W     = 5;
  localparam int HBSRE_RS_W      = 3;
  localparam int HBSRE_CFGSMP_W  = 16;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int HBSRE_CLK_MHZ         = 125;
  localparam int HBSRE_RELEASE_CLOCKS  = 2;
  localparam int HBSRE_AXI_OKAY        = 0;
  localparam logic [1:0] HBSRE_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HBSRE_RESP_SLVERR = 2'h2;
endpackage : hbsre_pkg

// *** hdl/hbsre_sync.sv ***
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hbsre_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  // Synchronous reset, so loading a port value is legal here
  genvar gi;
  for (gi = 0; gi < W; gi++) begin : g_bit
    always_comb begin
      meta_d[gi] = sys_rst ? rst_val[gi] : async_in[gi];
      sync_d[gi] = sys_rst ? rst_val[gi] : meta_q[gi];
    end
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;
endmodule : hbsre_sync
`default_nettype wire

// *** hdl/hbsre_axil.sv ***
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module hbsre_axil
  import hbsre_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_stb,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic        aw_have_q, aw_have_d;
  logic        w_have_q,  w_have_d;
  logic [7:0]  awaddr_q,  awaddr_d;
  logic [31:0] wdata_q,   wdata_d;
  logic [3:0]  wstrb_q,   wstrb_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        rvalid_q,  rvalid_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic [31:0] rdata_q,   rdata_d;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_stb  = aw_have_q && w_have_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_stb  = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (wr_stb) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? HBSRE_RESP_OKAY : HBSRE_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_stb) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_data;
      rresp_d  = rd_ok ? HBSRE_RESP_OKAY : HBSRE_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (sys_rst) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b0;
      rvalid_d  = 1'b0;
      awaddr_d  = 8'h00;
      wdata_d   = 32'h0000_0000;
      wstrb_d   = 4'h0;
      bresp_d   = HBSRE_RESP_OKAY;
      rresp_d   = HBSRE_RESP_OKAY;
      rdata_d   = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    aw_have_q <= aw_have_d;
    w_have_q  <= w_have_d;
    awaddr_q  <= awaddr_d;
    wdata_q   <= wdata_d;
    wstrb_q   <= wstrb_d;
    bvalid_q  <= bvalid_d;
    bresp_q   <= bresp_d;
    rvalid_q  <= rvalid_d;
    rresp_q   <= rresp_d;
    rdata_q   <= rdata_d;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;
endmodule : hbsre_axil
`default_nettype wire

// *** hdl/hbsre_top.sv ***
// Front system bus sideband: machine check, thermal alarm, reset, config sampling, response parity
`timescale 1ns/1ps
`default_nettype none
module hbsre_top
  import hbsre_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      bus_clk_in,
  input  wire logic                      bus_reset_n,
  input  wire logic                      power_good_in,
  input  wire logic                      soft_init_n,
  input  wire logic [HBSRE_CFGSMP_W-1:0] cfg_pins_n,
  input  wire logic                      machine_check_line_in,
  output logic                           machine_check_line_out,
  output logic                           machine_check_line_oe,
  input  wire logic                      thermal_alarm_line_in,
  output logic                           thermal_alarm_line_out,
  output logic                           thermal_alarm_line_oe,
  output logic                           internal_error_out_n,
  output logic [HBSRE_REQ_W-1:0]         request_cmd_out,
  output logic                           request_cmd_oe,
  output logic                           address_strobe_first_out,
  output logic                           address_strobe_first_oe,
  input  wire logic [HBSRE_RS_W-1:0]     response_status_lines_n,
  input  wire logic                      response_parity_line,
  output logic                           thermal_control_circuit,
  output logic                           cache_invalidate,
  output logic                           bist_start
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 8 + HBSRE_RS_W + HBSRE_CFGSMP_W;
  logic [SW-1:0] pins_raw, pins_s;
  logic          bclk_s, rst_n_s, pgood_s, init_n_s, mc_in_s, alarm_in_s, rsp_s;
  logic [HBSRE_RS_W-1:0]     rs_n_s;
  logic [HBSRE_CFGSMP_W-1:0] cfg_s;
  logic [SW-1:0] pins_rst;

  // Idle levels: active-low lines rest high
  assign pins_rst = {1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                     {HBSRE_RS_W{1'b1}}, {HBSRE_CFGSMP_W{1'b1}}};
  assign pins_raw = {bus_clk_in, bus_reset_n, power_good_in, soft_init_n, machine_check_line_in,
                     thermal_alarm_line_in, response_parity_line, 1'b1,
                     response_status_lines_n, cfg_pins_n};
  hbsre_sync #(.W(SW)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (pins_raw),
    .rst_val  (pins_rst),
    .sync_out (pins_s)
  );
  assign {bclk_s, rst_n_s, pgood_s, init_n_s, mc_in_s, alarm_in_s, rsp_s} = pins_s[SW-1:SW-7];
  assign rs_n_s = pins_s[HBSRE_RS_W+HBSRE_CFGSMP_W-1:HBSRE_CFGSMP_W];
  assign cfg_s  = pins_s[HBSRE_CFGSMP_W-1:0];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        wr_stb, rd_stb, wr_ok, rd_ok;
  logic [7:0]  wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;
  hbsre_axil u_axil (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_stb        (rd_stb),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [HBSRE_CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic [HBSRE_REQ_W-1:0]    reqcmd_q, reqcmd_d;
  logic [HBSRE_CFGSMP_W-1:0] cfg_q, cfg_d;
  logic [HBSRE_EV_W-1:0]     ev_q, ev_d;
  logic                      internal_error_out_q, internal_error_out_d;
  logic                      bist_q, bist_d;
  logic                      rst_n_q, rst_n_d;
  logic                      bclk_q, bclk_d;
  logic [1:0]                rel_cnt_q, rel_cnt_d;
  logic                      drive_q, drive_d;
  logic                      launch_q, launch_d;
  logic                      strobe_q, strobe_d;
  logic                      mcdrv_q, mcdrv_d;
  logic                      hot_q, hot_d;
  logic [1:0]                mc_hist_q, mc_hist_d;

  logic bus_rst, rst_rise, bclk_rise, par_ok, rs_driven, par_err, txn_err;

  assign bus_rst   = !rst_n_s;                       // Active-low reset pin
  assign rst_rise  = rst_n_s && !rst_n_q;
  assign bclk_rise = bclk_s && !bclk_q;
  assign rs_driven = |(~rs_n_s);
  // Even count of low lines gives high parity; idle 000 reads high and passes
  assign par_ok    = (rsp_s == ~(^(~rs_n_s)));
  assign par_err   = rs_driven && !par_ok && bclk_rise;
  assign txn_err   = ctrl_q[HBSRE_CTRL_TXN_ERR] || par_err;

  always_comb begin
    ctrl_d    = ctrl_q;
    reqcmd_d  = reqcmd_q;
    cfg_d     = cfg_q;
    ev_d      = ev_q;
    internal_error_out_d    = internal_error_out_q;
    bist_d    = 1'b0;
    rst_n_d   = rst_n_s;
    bclk_d    = bclk_s;
    rel_cnt_d = rel_cnt_q;
    drive_d   = drive_q;
    launch_d  = 1'b0;
    strobe_d  = 1'b0;
    mcdrv_d   = 1'b0;
    hot_d     = ctrl_q[HBSRE_CTRL_TEMP_HOT];
    mc_hist_d = {mc_hist_q[0], mcdrv_q};
    // Self-clearing launch bit, one command per write
    ctrl_d[HBSRE_CTRL_LAUNCH]   = 1'b0;
    ctrl_d[HBSRE_CTRL_INTERNAL_ERROR_OUT_SET] = 1'b0;
    ctrl_d[HBSRE_CTRL_TXN_ERR]  = 1'b0;
    if (wr_stb && wr_strb[0] && wr_addr == HBSRE_OFF_CTRL) begin
      ctrl_d[7:0] = wr_data[7:0];
    end
    if (wr_stb && wr_strb[1] && wr_addr == HBSRE_OFF_CTRL) begin
      ctrl_d[HBSRE_CTRL_W-1:8] = wr_data[HBSRE_CTRL_W-1:8];
    end
    if (wr_stb && wr_strb[0] && wr_addr == HBSRE_OFF_REQCMD) begin
      reqcmd_d = wr_data[HBSRE_REQ_W-1:0];
    end
    // Write one to clear; a new event in the same cycle wins
    if (wr_stb && wr_strb[0] && wr_addr == HBSRE_OFF_EVENT) begin
      ev_d = ev_q & ~wr_data[HBSRE_EV_W-1:0];
    end
    if (par_err) begin
      ev_d[HBSRE_EV_PARERR] = 1'b1;
    end
    // Own drive echoes back for two cycles through the synchroniser
    if (!mc_in_s && !mcdrv_q && mc_hist_q == 2'h0) begin
      ev_d[HBSRE_EV_MCSEEN] = 1'b1;                  // Other agents' reports
    end
    // Sticky until the next reset
    if (ctrl_q[HBSRE_CTRL_INTERNAL_ERROR_OUT_SET]) begin
      internal_error_out_d = 1'b1;
    end
    // Machine check sources, gated by enable
    if (ctrl_q[HBSRE_CTRL_MC_EN]) begin
      mcdrv_d = (ctrl_q[HBSRE_CTRL_MC_INTERNAL_ERROR_OUT] && internal_error_out_q) ||
                (ctrl_q[HBSRE_CTRL_MC_INIT] && drive_q && txn_err) ||
                (ctrl_q[HBSRE_CTRL_MC_ANY] && txn_err);
    end
    // Request command only while owner, launched with the first strobe
    if (ctrl_q[HBSRE_CTRL_LAUNCH] && ctrl_q[HBSRE_CTRL_OWNER] && rel_cnt_q == 2'd0) begin
      drive_d = 1'b1;
    end
    if (drive_q && bclk_rise && !bus_rst && ctrl_q[HBSRE_CTRL_OWNER]) begin
      strobe_d = 1'b1;
      launch_d = 1'b1;
    end
    if (launch_q) begin
      drive_d = 1'b0;
    end
    if (!ctrl_q[HBSRE_CTRL_OWNER]) begin
      drive_d = 1'b0;
    end
    // Pin reset: release everything within two clocks, invalidate state
    if (bus_rst) begin
      internal_error_out_d    = 1'b0;
      drive_d   = 1'b0;
      mcdrv_d   = 1'b0;
      hot_d     = 1'b0;
      rel_cnt_d = 2'(HBSRE_RELEASE_CLOCKS);
    end else if (rel_cnt_q != 2'd0) begin
      rel_cnt_d = rel_cnt_q - 2'd1;
    end
    // Configuration latched on the release edge
    if (rst_rise) begin
      cfg_d  = cfg_s;
      bist_d = !init_n_s;
    end
    if (sys_rst) begin
      ctrl_d    = HBSRE_CTRL_RST;
      reqcmd_d  = '0;
      cfg_d     = '1;
      ev_d      = '0;
      internal_error_out_d    = 1'b0;
      rst_n_d   = 1'b1;
      bclk_d    = 1'b0;
      rel_cnt_d = 2'd0;
      drive_d   = 1'b0;
      mcdrv_d   = 1'b0;
      hot_d     = 1'b0;
      mc_hist_d = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    ctrl_q    <= ctrl_d;
    reqcmd_q  <= reqcmd_d;
    cfg_q     <= cfg_d;
    ev_q      <= ev_d;
    internal_error_out_q    <= internal_error_out_d;
    bist_q    <= bist_d;
    rst_n_q   <= rst_n_d;
    bclk_q    <= bclk_d;
    rel_cnt_q <= rel_cnt_d;
    drive_q   <= drive_d;
    launch_q  <= launch_d;
    strobe_q  <= strobe_d;
    mcdrv_q   <= mcdrv_d;
    hot_q     <= hot_d;
    mc_hist_q <= mc_hist_d;
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Open drain: drive low only, enable while asserting
  assign machine_check_line_out   = 1'b0;
  assign machine_check_line_oe    = mcdrv_q;
  assign thermal_alarm_line_out   = 1'b0;
  assign thermal_alarm_line_oe    = hot_q;
  assign internal_error_out_n     = !internal_error_out_q;
  assign request_cmd_out          = ~reqcmd_q;
  assign request_cmd_oe           = drive_q;
  assign address_strobe_first_out = !strobe_q;
  assign address_strobe_first_oe  = drive_q;
  // Own drive echoes in alarm_in_s; hot_q follows HBSRE_CTRL_TEMP_HOT only, so the alarm cannot latch itself on
  assign thermal_control_circuit  = ctrl_q[HBSRE_CTRL_TCC_EN] && (hot_q || !alarm_in_s);
  assign cache_invalidate         = bus_rst;
  assign bist_start               = bist_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (rd_addr)
      HBSRE_OFF_CTRL:   rd_data[HBSRE_CTRL_W-1:0] = ctrl_q;
      HBSRE_OFF_STATUS: begin
        rd_data[HBSRE_ST_INTERNAL_ERROR_OUT]   = internal_error_out_q;
        rd_data[HBSRE_ST_TCC]    = thermal_control_circuit;
        rd_data[HBSRE_ST_MCDRV]  = mcdrv_q;
        rd_data[HBSRE_ST_MCIN]   = !mc_in_s;
        rd_data[HBSRE_ST_PGOOD]  = pgood_s;
        rd_data[HBSRE_ST_RESET]  = bus_rst;
        rd_data[HBSRE_ST_BIST]   = bist_q;
        rd_data[HBSRE_ST_ALRMIN] = !alarm_in_s;
      end
      HBSRE_OFF_REQCMD: rd_data[HBSRE_REQ_W-1:0] = reqcmd_q;
      HBSRE_OFF_CFG:    rd_data[HBSRE_CFGSMP_W-1:0] = cfg_q;
      HBSRE_OFF_EVENT:  rd_data[HBSRE_EV_W-1:0] = ev_q;
      default:          rd_ok = 1'b0;
    endcase
  end

  assign wr_ok = (wr_addr == HBSRE_OFF_CTRL) || (wr_addr == HBSRE_OFF_REQCMD) ||
                 (wr_addr == HBSRE_OFF_EVENT);
endmodule : hbsre_top
`default_nettype wire

// *** test/hbsre_properties.sv ***
// Checker: port-level timing properties of the sideband block
`timescale 1ns/1ps
`default_nettype none
module hbsre_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_reset_n,
  input wire logic machine_check_line_out,
  input wire logic machine_check_line_oe,
  input wire logic thermal_alarm_line_out,
  input wire logic thermal_alarm_line_oe,
  input wire logic request_cmd_oe,
  input wire logic address_strobe_first_out,
  input wire logic address_strobe_first_oe,
  input wire logic internal_error_out_n,
  input wire logic cache_invalidate,
  input wire logic bist_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pin low long enough to pass both synchroniser stages
  sequence rst_low_s;
    !bus_reset_n [*3];
  endsequence
  out_release_a: assert property (rst_low_s |=> !(machine_check_line_oe | thermal_alarm_line_oe
    | request_cmd_oe | address_strobe_first_oe)) else $error("bus output driven in reset");
  cache_inval_a: assert property (rst_low_s |=> cache_invalidate) else $error("caches kept");
  internal_error_out_clear_a: assert property (rst_low_s |=> internal_error_out_n) else $error("internal_error_out kept");
  internal_error_out_sticky_a: assert property (!internal_error_out_n && bus_reset_n |=> !internal_error_out_n)
    else $error("internal_error_out dropped early");
  strobe_pulse_a: assert property ($fell(address_strobe_first_out) |=> address_strobe_first_out)
    else $error("strobe too long");
  strobe_owner_a: assert property (!address_strobe_first_out |-> address_strobe_first_oe && request_cmd_oe)
    else $error("strobe without ownership");
  mc_low_a: assert property (machine_check_line_oe |-> !machine_check_line_out) else $error("mc drives high");
  alarm_low_a: assert property (thermal_alarm_line_oe |-> !thermal_alarm_line_out) else $error("alarm high");
  bist_pulse_a: assert property (bist_start |=> !bist_start) else $error("bist pulse too long");
endmodule // hbsre_properties
bind hbsre_top hbsre_properties prop_u (.*);
`default_nettype wire

// *** test/hbsre_agent.sv ***
// Partner model: bus clock, response agent, pulled-up sideband lines
`timescale 1ns/1ps
`default_nettype none
module hbsre_agent (
  input  wire logic  machine_check_line_out,
  input  wire logic  machine_check_line_oe,
  input  wire logic  thermal_alarm_line_out,
  input  wire logic  thermal_alarm_line_oe,
  output logic       bus_clk_in,
  output logic [2:0] response_status_lines_n,
  output logic       response_parity_line,
  output logic       machine_check_line_in,
  output logic       thermal_alarm_line_in
);
  logic mc_pull = 1'b0;
  logic alarm_pull = 1'b0;
  initial begin
    bus_clk_in = 1'b0;
    response_status_lines_n = 3'h7;
    response_parity_line = 1'b1;
  end
  // Free-running bus clock, edges coincide with clk falling edges
  always #80 bus_clk_in = ~bus_clk_in;
  // Pulled up; low while any agent sinks it
  assign machine_check_line_in = (machine_check_line_oe ? machine_check_line_out : 1'b1) & !mc_pull;
  assign thermal_alarm_line_in = (thermal_alarm_line_oe ? thermal_alarm_line_out : 1'b1) & !alarm_pull;
  task automatic pull(input logic m, input logic a);
    mc_pull <= m;
    alarm_pull <= a;
  endtask
  // Falling-edge launch keeps status settled around the sampling edge
  task automatic respond(input logic [2:0] rs_n, input logic bad);
    @(negedge bus_clk_in);
    response_status_lines_n <= rs_n;
    response_parity_line <= ^rs_n ^ bad;
    @(negedge bus_clk_in);
    response_status_lines_n <= 3'h7;
    response_parity_line <= 1'b1;
  endtask
endmodule // hbsre_agent
`default_nettype wire

// *** test/tb_top.sv ***
// Testbench: register-driven scenarios for the sideband block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb_top import hbsre_pkg::*; ;
  localparam logic [1:0]  OK = HBSRE_RESP_OKAY;
  localparam logic [1:0]  ER = HBSRE_RESP_SLVERR;
  localparam logic [31:0] AL = 32'hffffffff;
  logic clk = 1'b0, sys_rst = 1'b1, power_good_in = 1'b0, bus_reset_n = 1'b1, soft_init_n = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [15:0] cfg_pins_n = 16'hffff;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  response_status_lines_n;
  logic [4:0]  request_cmd_out, cmd_seen = 5'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_clk_in, response_parity_line;
  logic machine_check_line_in, machine_check_line_out, machine_check_line_oe, thermal_alarm_line_in;
  logic thermal_alarm_line_out, thermal_alarm_line_oe, internal_error_out_n, request_cmd_oe, cache_invalidate;
  logic address_strobe_first_out, address_strobe_first_oe, thermal_control_circuit, bist_start;
  logic bist_seen = 1'b0, strobe_seen = 1'b0;
  int   err_total = 0, check_count = 0, cyc = 0, n;
  hbsre_top dut_u (.*);
  hbsre_agent agent_u (.*);
  always #4 clk = ~clk;
  // Pulses are caught here, they last one cycle only
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (bist_start)
      bist_seen <= 1'b1;
    if (!address_strobe_first_out && address_strobe_first_oe) begin
      strobe_seen <= 1'b1;
      cmd_seen <= request_cmd_out;
    end
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       aw_rdy, w_rdy, b_vld;
    logic [1:0] resp;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      {aw_rdy, w_rdy, b_vld, resp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge clk);
      if (aw_rdy)
        s_axi_awvalid <= 1'b0;
      if (w_rdy)
        s_axi_wvalid <= 1'b0;
    end while (!b_vld);
    s_axi_bready <= 1'b0;
    `CHK("bresp", resp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic        ar_rdy, r_vld;
    logic [31:0] data;
    logic [1:0]  resp;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      {ar_rdy, r_vld, data, resp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ar_rdy)
        s_axi_arvalid <= 1'b0;
    end while (!r_vld);
    s_axi_rready <= 1'b0;
    `CHK("rdata", data & m, e)
    `CHK("rresp", resp, er)
  endtask
  task automatic bus_rst(input logic [15:0] cfg, input logic si_n);
    @(posedge clk);
    bus_reset_n <= 1'b0;
    cfg_pins_n <= cfg;
    soft_init_n <= si_n;
    repeat (8) @(posedge clk); // scaled-down hold, far below the ceiling
    bus_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    soft_init_n <= 1'b1;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    power_good_in <= 1'b1;
    rd(HBSRE_OFF_CTRL, AL, 32'h0, OK);
    rd(HBSRE_OFF_CFG, AL, 32'hffff, OK);
    wr(8'h14, 32'h1, ER);
    rd(8'h14, AL, 32'h0, ER);
    wr(HBSRE_OFF_STATUS, 32'h1, ER);
    `CHK("bist_idle", bist_seen, 1'b0)
    bus_rst(16'ha5c3, 1'b0);
    `CHK("bist", bist_seen, 1'b1)
    rd(HBSRE_OFF_CFG, AL, 32'ha5c3, OK);
    wr(HBSRE_OFF_CTRL, 32'h43, OK);
    repeat (30) @(posedge clk);
    `CHK("internal_error_out", internal_error_out_n, 1'b0)
    `CHK("mc_internal_error_out", machine_check_line_oe, 1'b1)
    rd(HBSRE_OFF_STATUS, 32'h15, 32'h15, OK);
    bus_rst(16'h0f0f, 1'b1);
    `CHK("internal_error_out_clr", internal_error_out_n, 1'b1)
    `CHK("mc_rel", machine_check_line_oe, 1'b0)
    wr(HBSRE_OFF_CTRL, 32'h09, OK);
    for (n = 0; n < 8; n++)
      agent_u.respond(n[2:0], 1'b0);
    rd(HBSRE_OFF_EVENT, 32'h1, 32'h0, OK);
    agent_u.respond(3'h6, 1'b1);
    repeat (6) @(posedge clk);
    rd(HBSRE_OFF_EVENT, 32'h1, 32'h1, OK);
    wr(HBSRE_OFF_EVENT, 32'h1, OK);
    rd(HBSRE_OFF_EVENT, 32'h3, 32'h0, OK);
    wr(HBSRE_OFF_CTRL, 32'hca, OK);
    repeat (3) @(posedge clk);
    `CHK("mc_off", machine_check_line_oe, 1'b0)
    agent_u.pull(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    rd(HBSRE_OFF_EVENT, 32'h2, 32'h2, OK);
    agent_u.pull(1'b0, 1'b0);
    wr(HBSRE_OFF_CTRL, 32'h30, OK);
    repeat (2) @(posedge clk);
    `CHK("alarm_drv", thermal_alarm_line_oe, 1'b1)
    `CHK("tcc_hot", thermal_control_circuit, 1'b1)
    wr(HBSRE_OFF_CTRL, 32'h10, OK);
    agent_u.pull(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    `CHK("tcc_in", thermal_control_circuit, 1'b1)
    agent_u.pull(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    `CHK("tcc_rel", thermal_control_circuit, 1'b0)
    wr(HBSRE_OFF_REQCMD, 32'h13, OK);
    wr(HBSRE_OFF_CTRL, 32'h300, OK);
    for (n = 0; n < 60 && !strobe_seen; n++)
      @(posedge clk);
    `CHK("strobe", strobe_seen, 1'b1)
    `CHK("req_cmd", cmd_seen, ~5'h13)
    repeat (4) @(posedge clk);
    `CHK("req_rel", request_cmd_oe, 1'b0)
    final_report();
  end
endmodule // tb_top
`default_nettype wire
